// ==== design/codec_control_register_bank.sv ====
/*
 * Software control register bank of a stereo audio codec: receives
 * 16-bit words on the three-wire control link and holds the four
 * program registers that steer the DAC, ADC and data format.
 * Assumes the link pins are asynchronous to ref_clk and slow enough
 * (shift clock period well above four ref_clk periods) to be
 * oversampled after two-flop synchronisation.
 */
//
// Function
// RQ1 - Four sixteen-bit program registers hold all functions
// RQ2 - Bits ten and nine select target register
// RQ3 - Host writes zeros into bits fifteen to eleven
// RQ4 - Select 00: left load bit and code
// RQ5 - Select 01: right load bit and code
// RQ6 - Select 10: power, filter, mute, emphasis fields
// RQ7 - Select 11: loopback, format, clock polarity fields
// RQ8 - Load bit one applies the carried code
// RQ9 - Load bit zero keeps the previous level
// RQ10 - Either load bit updates both channels together
// RQ11 - Gain is code over 256, log scale; the code uses a linear factor of code/256
// RQ12 - FFh unity default, 00h mute, 01h lowest
// RQ13 - Words arrive on clock, data, latch wires
// RQ14 - Latch rise after last bit commits word
// RQ15 - Shared mode applies left code to both
// RQ16 - Partial words never change any register
`default_nettype none
module codec_control_register_bank
	import codec_ctrl_pkg::*;
(
	input wire logic ref_clk, // System clock, 100 MHz
	input wire logic rst_n, // Async reset, active low
	input wire logic ctrl_shift_clock, // Link shift clock pin
	input wire logic ctrl_serial_data, // Link data pin, MSB first
	input wire logic ctrl_latch, // Link latch pin
	output logic [CODE_W-1:0] left_gain_code, // Applied left code
	output logic [CODE_W-1:0] right_gain_code, // Applied right code
	output logic [FACTOR_W-1:0] left_gain_factor, // Left gain x256
	output logic [FACTOR_W-1:0] right_gain_factor, // Right gain x256
	output logic level_update, // Pulse: both levels reloaded
	output logic adc_sleep, // ADC power-down
	output logic highpass_skip, // ADC high-pass bypass
	output logic dac_sleep, // DAC power-down
	output logic shared_gain_mode, // Common attenuation mode
	output logic zero_run_mute_enable, // Zero-detect mute enable
	output logic dac_output_disable, // DAC outputs forced to mid
	output logic [1:0] deemph_select, // De-emphasis select
	output logic soft_silence, // Soft mute of both channels
	output logic adc_to_dac_loop, // Digital loopback
	output logic [1:0] sample_format_select, // Audio data format
	output logic channel_clock_polarity, // Left/right clock polarity
	output logic word_taken, // Pulse: full word committed
	output logic word_dropped // Pulse: latch on a partial word
);
	// Link framing states
	typedef enum logic [2:0] {
		LINK_IDLE = 3'b001,
		LINK_SHIFT = 3'b010,
		LINK_FULL = 3'b100
	} link_state_t;

	logic clk_s;
	logic data_s;
	logic latch_s;
	logic clk_d;
	logic latch_d;
	logic clk_rise;
	logic latch_rise;
	link_state_t link_state;
	link_state_t next_link_state;
	logic [WORD_W-1:0] shift_word;
	logic [BIT_CNT_W-1:0] bit_count;
	logic commit;
	reg_sel_t sel;
	logic [BODY_W-1:0] body;
	logic [BODY_W-1:0] left_attenuation;
	logic [BODY_W-1:0] right_attenuation;
	logic [BODY_W-1:0] function_control;
	logic [BODY_W-1:0] format_control;
	logic load_request;

	// Register select sits in bits ten and nine of every word
	function automatic reg_sel_t word_select(
		input logic [WORD_W-1:0] w);
		return reg_sel_t'(w[ADDR_HI:ADDR_LO]); // [RQ2]
	endfunction

	// Reserved upper bits are ignored; only the body is kept
	function automatic logic [BODY_W-1:0] word_body(
		input logic [WORD_W-1:0] w);
		return w[BODY_W-1:0]; // [RQ3]
	endfunction

	// All three link pins come from another domain
	pin_sync #(
		.W(3)
	) u_pin_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.d({ctrl_shift_clock, ctrl_serial_data, ctrl_latch}),
		.q({clk_s, data_s, latch_s})
	);

	// Edge detectors on the synchronised pins; the data pin has passed
	// the same two flops, so it lines up with the clock edge it met
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_d <= 1'b0;
			latch_d <= 1'b0;
		end else begin
			clk_d <= clk_s;
			latch_d <= latch_s;
		end
	end

	assign clk_rise = clk_s & ~clk_d; // [RQ13]
	assign latch_rise = latch_s & ~latch_d; // [RQ14]

	// Framing: a latch edge ends every frame, complete or not
	always_comb begin
		next_link_state = link_state;
		unique case (link_state)
			LINK_IDLE: begin
				if (latch_rise)
					next_link_state = LINK_IDLE;
				else if (clk_rise)
					next_link_state = LINK_SHIFT;
			end
			LINK_SHIFT: begin
				if (latch_rise)
					next_link_state = LINK_IDLE;
				else if (clk_rise && bit_count == WORD_BITS - 5'h01)
					next_link_state = LINK_FULL;
			end
			LINK_FULL: begin
				if (latch_rise)
					next_link_state = LINK_IDLE;
			end
			default: next_link_state = LINK_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			link_state <= LINK_IDLE;
		else
			link_state <= next_link_state;
	end

	// Shift register: extra bits push the oldest out, so the last
	// sixteen before the latch are the word that counts
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			shift_word <= '0;
		else if (clk_rise && !latch_rise)
			shift_word <= {shift_word[WORD_W-2:0], data_s}; // [RQ13]
	end

	// Bit counter saturates at a full word and clears on every latch
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			bit_count <= '0;
		else if (latch_rise)
			bit_count <= '0;
		else if (clk_rise && bit_count != WORD_BITS)
			bit_count <= bit_count + 5'h01;
	end

	// Only a latch that closes a full word may touch the registers
	assign commit = latch_rise && (link_state == LINK_FULL); // [RQ14] [RQ16]
	assign sel = word_select(shift_word);
	assign body = word_body(shift_word);
	assign load_request = commit && body[LOAD_BIT] &&
		(sel == SEL_LEFT || sel == SEL_RIGHT); // [RQ8] [RQ10]

	// Frame outcome pulses
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			word_taken <= 1'b0;
			word_dropped <= 1'b0;
		end else begin
			word_taken <= commit;
			word_dropped <= latch_rise && !commit; // [RQ16]
		end
	end

	// Left register: load bit and code; the code is kept as the
	// staged value even when the level is not reloaded
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			left_attenuation <= LEFT_RESET;
		else if (commit && sel == SEL_LEFT)
			left_attenuation <= body; // [RQ1] [RQ4]
	end

	// Right register, same layout as the left one
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			right_attenuation <= RIGHT_RESET;
		else if (commit && sel == SEL_RIGHT)
			right_attenuation <= body; // [RQ1] [RQ5]
	end

	// Function register: power, filter, mute and emphasis controls
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			function_control <= FUNCTION_RESET;
		else if (commit && sel == SEL_FUNCTION)
			function_control <= body; // [RQ1] [RQ6]
	end

	// Format register: reserved positions are forced to zero
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			format_control <= FORMAT_RESET;
		else if (commit && sel == SEL_FORMAT)
			format_control <= body & FORMAT_MASK; // [RQ1] [RQ7]
	end

	// Applied levels move together: the channel just written takes
	// its new code, the other takes its staged code. A write with the
	// load bit clear leaves both applied levels alone.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			left_gain_code <= CODE_UNITY; // [RQ12]
			right_gain_code <= CODE_UNITY;
		end else if (load_request) begin
			if (sel == SEL_LEFT) begin
				left_gain_code <= body[CODE_W-1:0]; // [RQ8] [RQ10]
				right_gain_code <= right_attenuation[CODE_W-1:0];
			end else begin
				left_gain_code <= left_attenuation[CODE_W-1:0];
				right_gain_code <= body[CODE_W-1:0]; // [RQ8] [RQ10]
			end
		end
	end // [RQ9]

	// Update strobe for the datapath, raised with the new codes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			level_update <= 1'b0;
		else
			level_update <= load_request;
	end

	// Control outputs straight from the register flops
	assign adc_sleep = function_control[ADC_SLEEP_BIT]; // [RQ6]
	assign highpass_skip = function_control[HPF_SKIP_BIT];
	assign dac_sleep = function_control[DAC_SLEEP_BIT];
	assign shared_gain_mode = function_control[SHARED_BIT];
	assign zero_run_mute_enable = function_control[ZERO_MUTE_BIT];
	assign dac_output_disable = function_control[OUT_DIS_BIT];
	assign deemph_select = function_control[DEEMPH_HI:DEEMPH_LO];
	assign soft_silence = function_control[SILENCE_BIT];
	assign adc_to_dac_loop = format_control[LOOP_BIT]; // [RQ7]
	assign sample_format_select = format_control[FORMAT_HI:FORMAT_LO];
	assign channel_clock_polarity = format_control[POLARITY_BIT];

	// Linear factors; shared mode is resolved here so a mode change
	// takes effect one ref_clk cycle later without waiting for a load
	level_scaler u_level_scaler (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.left_code(left_gain_code),
		.right_code(right_gain_code),
		.shared_gain_mode(shared_gain_mode), // [RQ15]
		.left_factor(left_gain_factor),
		.right_factor(right_gain_factor)
	);
endmodule
`default_nettype wire

// ==== design/codec_ctrl_pkg.sv ====
/*
 * Shared constants for the codec control register bank: word layout,
 * register selects, field positions and reset values.
 * Assumes a single 100 MHz system clock domain for all users.
 */
`default_nettype none
package codec_ctrl_pkg;
	localparam int WORD_W = 16;
	localparam int BIT_CNT_W = 5;
	localparam logic [BIT_CNT_W-1:0] WORD_BITS = 5'h10;
	localparam int ADDR_HI = 10;
	localparam int ADDR_LO = 9;
	localparam int BODY_W = 9;
	localparam int CODE_W = 8;
	localparam int FACTOR_W = 9;
	// Bit positions inside a register body
	localparam int LOAD_BIT = 8;
	localparam int ADC_SLEEP_BIT = 8;
	localparam int HPF_SKIP_BIT = 7;
	localparam int DAC_SLEEP_BIT = 6;
	localparam int SHARED_BIT = 5;
	localparam int ZERO_MUTE_BIT = 4;
	localparam int OUT_DIS_BIT = 3;
	localparam int DEEMPH_HI = 2;
	localparam int DEEMPH_LO = 1;
	localparam int SILENCE_BIT = 0;
	localparam int LOOP_BIT = 5;
	localparam int FORMAT_HI = 3;
	localparam int FORMAT_LO = 2;
	localparam int POLARITY_BIT = 1;
	// Writable bits of the format register; the others are reserved
	localparam logic [BODY_W-1:0] FORMAT_MASK = 9'h02E;
	// Reset values of the register bodies
	localparam logic [BODY_W-1:0] LEFT_RESET = 9'h0FF;
	localparam logic [BODY_W-1:0] RIGHT_RESET = 9'h0FF;
	localparam logic [BODY_W-1:0] FUNCTION_RESET = 9'h002;
	localparam logic [BODY_W-1:0] FORMAT_RESET = 9'h000;
	localparam logic [CODE_W-1:0] CODE_UNITY = 8'hFF;
	localparam logic [FACTOR_W-1:0] FACTOR_UNITY = 9'h100;
	typedef enum logic [1:0] {
		SEL_LEFT = 2'h0,
		SEL_RIGHT = 2'h1,
		SEL_FUNCTION = 2'h2,
		SEL_FORMAT = 2'h3
	} reg_sel_t;
endpackage
`default_nettype wire

// ==== design/level_scaler.sv ====
/*
 * Turns the applied attenuation codes into linear gain factors
 * (factor / 256 is the gain) for the DAC datapath.
 * Assumes the codes change only on a committed level update.
 */
`default_nettype none
module level_scaler
	import codec_ctrl_pkg::*;
(
	input wire logic ref_clk, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic [CODE_W-1:0] left_code, // Applied left code
	input wire logic [CODE_W-1:0] right_code, // Applied right code
	input wire logic shared_gain_mode, // Left code drives both
	output logic [FACTOR_W-1:0] left_factor, // Left gain x256
	output logic [FACTOR_W-1:0] right_factor // Right gain x256
);
	// Code n gives n/256; the top code is unity rather than 255/256
	function automatic logic [FACTOR_W-1:0] code_to_factor(
		input logic [CODE_W-1:0] code);
		if (code == CODE_UNITY)
			return FACTOR_UNITY; // [RQ12]
		return {1'b0, code}; // [RQ11] [RQ12]
	endfunction

	// Registered so the datapath sees both channels move together
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			left_factor <= FACTOR_UNITY;
			right_factor <= FACTOR_UNITY;
		end else begin
			left_factor <= code_to_factor(left_code);
			if (shared_gain_mode)
				right_factor <= code_to_factor(left_code); // [RQ15]
			else
				right_factor <= code_to_factor(right_code);
		end
	end
endmodule
`default_nettype wire

// ==== design/pin_sync.sv ====
/*
 * Two-flop synchroniser for a group of independent level signals.
 * Assumes each bit is a slow level from outside the ref_clk domain.
 */
`default_nettype none
module pin_sync #(
	parameter int W = 3
) (
	input wire logic ref_clk, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic [W-1:0] d, // Asynchronous inputs
	output logic [W-1:0] q // Synchronised copies
);
	logic [W-1:0] meta;

	// First stage feeds only the second; nothing else may look at it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule
`default_nettype wire

// ==== verif/codec_bank_checker.sv ====
/*
 * Port-level assertions for the codec control register bank.
 * Assumes one ref_clk domain and the bind at the foot of this file.
 */
`default_nettype none
module codec_bank_checker
	import codec_ctrl_pkg::*;
(
	input wire logic ref_clk, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic ctrl_latch, // Link latch pin
	input wire logic [CODE_W-1:0] left_gain_code, // Applied left code
	input wire logic [CODE_W-1:0] right_gain_code, // Applied right code
	input wire logic [FACTOR_W-1:0] left_gain_factor, // Left factor
	input wire logic [FACTOR_W-1:0] right_gain_factor, // Right factor
	input wire logic level_update, // Reload pulse
	input wire logic shared_gain_mode, // Common gain mode
	input wire logic adc_sleep, // ADC power-down
	input wire logic [1:0] deemph_select, // De-emphasis
	input wire logic [1:0] sample_format_select, // Data format
	input wire logic word_taken, // Commit pulse
	input wire logic word_dropped // Drop pulse
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// A commit needs a whole word, so pulses cannot crowd
	a_taken_spacing: assert property (
		word_taken |=> !word_taken [*8])
		else $error("commit pulses too close");
	a_latch_cause: assert property (
		word_taken |-> $past(ctrl_latch, 2))
		else $error("commit without latch");
	// Applied levels move only on a commit, with the reload strobe
	a_code_cause: assert property (
		$changed(left_gain_code) || $changed(right_gain_code) |-> word_taken)
		else $error("level moved without commit");
	a_level_both: assert property (
		$changed(left_gain_code) || $changed(right_gain_code) |-> level_update)
		else $error("level change without reload");
	a_level_cause: assert property (
		level_update |-> word_taken)
		else $error("reload without commit");
	a_left_factor: assert property (
		$stable(left_gain_code) |-> left_gain_factor == ((left_gain_code ==
		CODE_UNITY) ? FACTOR_UNITY : {1'b0, left_gain_code}))
		else $error("left factor wrong");
	a_shared_gain: assert property (
		shared_gain_mode ##1 shared_gain_mode |->
		right_gain_factor == left_gain_factor)
		else $error("shared mode not applied");
	a_func_cause: assert property (
		$changed(adc_sleep) || $changed(deemph_select) ||
		$changed(sample_format_select) |-> word_taken)
		else $error("control moved without commit");
	a_drop_quiet: assert property (
		word_dropped |-> !word_taken && $stable(left_gain_code) &&
		$stable(deemph_select))
		else $error("partial word changed state");
endmodule
bind codec_control_register_bank codec_bank_checker chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .ctrl_latch(ctrl_latch),
	.left_gain_code(left_gain_code), .right_gain_code(right_gain_code),
	.left_gain_factor(left_gain_factor),
	.right_gain_factor(right_gain_factor), .level_update(level_update),
	.shared_gain_mode(shared_gain_mode), .adc_sleep(adc_sleep),
	.deemph_select(deemph_select),
	.sample_format_select(sample_format_select),
	.word_taken(word_taken), .word_dropped(word_dropped));
`default_nettype wire

// ==== verif/link_host_model.sv ====
/*
 * Host side of the three-wire control link, driven by a task.
 * Assumes the bench calls send and waits for it to return.
 */
`default_nettype none
module link_host_model (
	output logic ctrl_shift_clock, // Shift clock, still between frames
	output logic ctrl_serial_data, // Data, MSB first
	output logic ctrl_latch // Latch, rise commits the word
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		ctrl_shift_clock = 1'b0;
		ctrl_serial_data = 1'b0;
		ctrl_latch = 1'b0;
	end
	// Sends the top n bits of w with a 125 ns shift period; equal
	// half periods keep every pin edge off the rising ref_clk edge
	task automatic send(input logic [15:0] w, input int n);
		for (int k = 15; k > 15 - n; k--) begin
			ctrl_serial_data = w[k];
			#62.5 ctrl_shift_clock = 1'b1;
			#62.5 ctrl_shift_clock = 1'b0;
		end
		ctrl_latch = 1'b1; // After the last rise
		#100 ctrl_latch = 1'b0;
		// Released data line must not keep showing the last bit
		ctrl_serial_data = ~ctrl_serial_data;
		#100;
	endtask
endmodule
`default_nettype wire

// ==== verif/tb_codec_control_register_bank.sv ====
/*
 * Self-checking bench for the codec control register bank.
 * Assumes the host model drives the link; bench compares a model.
 */
`default_nettype none
module tb_codec_control_register_bank
	import codec_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	wire logic sck, sda, sla;
	logic [7:0] lc, rc, st_l, st_r, ap_l, ap_r;
	logic [8:0] lf, rf, fn, fm;
	logic lu, ad, hs, ds, sg, zm, od, sl, lp, cp, wt, wd;
	logic [1:0] dm, sf;
	int bad_count = 0;
	int checked = 0;
	int taken = 0, dropped = 0, exp_t = 0, exp_d = 0, i;
	int seed = 32'h842a9668;
	codec_control_register_bank dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.ctrl_shift_clock(sck), .ctrl_serial_data(sda), .ctrl_latch(sla),
		.left_gain_code(lc), .right_gain_code(rc), .left_gain_factor(lf),
		.right_gain_factor(rf), .level_update(lu), .adc_sleep(ad),
		.highpass_skip(hs), .dac_sleep(ds), .shared_gain_mode(sg),
		.zero_run_mute_enable(zm), .dac_output_disable(od),
		.deemph_select(dm), .soft_silence(sl), .adc_to_dac_loop(lp),
		.sample_format_select(sf), .channel_clock_polarity(cp),
		.word_taken(wt), .word_dropped(wd));
	link_host_model host (.ctrl_shift_clock(sck), .ctrl_serial_data(sda),
		.ctrl_latch(sla));
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	// Pulses stand one cycle, so count them at every edge
	always @(posedge ref_clk) begin
		taken += int'(wt === 1'b1);
		dropped += int'(wd === 1'b1);
	end
	function automatic logic [8:0] fac(input logic [7:0] c);
		return (c == 8'hFF) ? 9'h100 : {1'b0, c};
	endfunction
	task cmp(input logic [8:0] g, input logic [8:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task end_of_test;
		if (bad_count == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task mreset;
		st_l = 8'hFF;
		st_r = 8'hFF;
		ap_l = 8'hFF;
		ap_r = 8'hFF;
		fn = 9'h002;
		fm = 9'h000;
	endtask
	task check;
		cmp({1'b0, lc}, {1'b0, ap_l});
		cmp({1'b0, rc}, {1'b0, ap_r});
		cmp(lf, fac(ap_l));
		cmp(rf, fn[5] ? fac(ap_l) : fac(ap_r));
		cmp({ad, hs, ds, sg, zm, od, dm, sl}, fn);
		cmp({3'h0, lp, 1'b0, sf, cp, 1'b0}, fm);
		cmp(9'(taken), 9'(exp_t));
		cmp(9'(dropped), 9'(exp_d));
	endtask
	// Sends a word, steps the model, then compares after settling
	task put(input logic [15:0] w, input int n);
		host.send(w, n);
		if (n < 16) begin
			exp_d++;
		end else begin
			exp_t++;
			if (w[10:9] == 2'h0) st_l = w[7:0];
			if (w[10:9] == 2'h1) st_r = w[7:0];
			if (!w[10] && w[8]) begin
				ap_l = st_l;
				ap_r = st_r;
			end
			if (w[10:9] == 2'h2) fn = w[8:0];
			if (w[10:9] == 2'h3) fm = w[8:0] & 9'h02E;
		end
		check();
	endtask
	initial begin
		mreset();
		repeat (5) @(posedge ref_clk);
		@(negedge ref_clk) rst_n = 1'b1;
		repeat (3) @(posedge ref_clk);
		#3 check();
		put(16'h0001, 16);
		put(16'h0300, 16);
		put(16'h04A0, 9);
		put(16'h0420, 16);
		put(16'h0155, 16);
		for (i = 0; i < 4; i++) begin
			put({7'h02, 6'h0, i[1:0], 1'b1}, 16);
			put({7'h03, 3'h7, 2'h3, i[1:0], 2'h3}, 16);
		end
		repeat (60) put({5'h0, 11'($random(seed))}, 16);
		// Second reset in mid-run returns every field to default
		@(negedge ref_clk) rst_n = 1'b0;
		repeat (2) @(posedge ref_clk);
		mreset();
		@(negedge ref_clk) rst_n = 1'b1;
		repeat (3) @(posedge ref_clk);
		#3 check();
		end_of_test();
	end
	// About 75 words of 2.2 us each; cut off well beyond that
	initial begin
		#400000;
		bad_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
